// File: hdl/dosm_pkg.sv
/*
 Shared constants and types for the OUT stream move-data link.
 Assumes both ends run on one 40 MHz clock with a synchronous reset.
*/
package dosm_pkg;
    localparam int SID_W = 16;
    localparam int NUMP_W = 5;
    localparam logic [15:0] SID_NOSTREAM = 16'h0000;
    localparam logic [15:0] SID_PRIME = 16'hFFFE;
    localparam logic [4:0] NUMP_ZERO = 5'h00;
    localparam logic [4:0] NUMP_RESET = 5'h01;
    localparam logic [15:0] SID_RESET = 16'h0000;
    localparam int HOST_GAP_CYCLES = 2;

    typedef enum logic [1:0] {
        DOSM_RSP_ACK = 2'h1,
        DOSM_RSP_NRDY = 2'h2
    } dosm_rsp_e;

    typedef enum logic [5:0] {
        DOSM_IDLE = 6'h01,
        DOSM_SS = 6'h02,
        DOSM_SS_END = 6'h04,
        DOSM_DEV = 6'h08,
        DOSM_HOST = 6'h10,
        DOSM_HTERM = 6'h20
    } dosm_state_e;
endpackage : dosm_pkg

// File: hdl/dosm_link_if.sv
/*
 Link carrier between device end and host end of the OUT stream pipe.
 Assumes single clock; packets are one-cycle valid pulses.
*/
`timescale 1ns/100ps
interface dosm_link_if (
    input wire logic clk
);
    logic dp_valid;
    logic [15:0] dp_sid;
    logic dp_pp;
    logic dp_err;
    logic dp_deferred;
    logic dp_zero_len;
    logic rsp_valid;
    dosm_pkg::dosm_rsp_e rsp_kind;
    logic [15:0] rsp_sid;
    logic [4:0] rsp_nump;
    logic rsp_rty;

    modport dev (
        input dp_valid, dp_sid, dp_pp, dp_err, dp_deferred, dp_zero_len,
        output rsp_valid, rsp_kind, rsp_sid, rsp_nump, rsp_rty
    );
    modport host (
        output dp_valid, dp_sid, dp_pp, dp_err, dp_deferred, dp_zero_len,
        input rsp_valid, rsp_kind, rsp_sid, rsp_nump, rsp_rty
    );
endinterface : dosm_link_if

// File: hdl/dosm_sid_check.sv
/*
 Stream ID checker: flags a packet whose ID differs from the current stream.
 Assumes inputs are synchronous to clk.
*/
`timescale 1ns/100ps
module dosm_sid_check (
    input wire logic clk,
    input wire logic rst,
    input wire logic check_en,
    input wire logic [15:0] pkt_sid,
    input wire logic [15:0] cur_sid,
    output logic mismatch
);
    wire differ = check_en && (pkt_sid != cur_sid);

    always_ff @(posedge clk) begin
        if (rst) begin
            mismatch <= 1'b0;
        end else begin
            mismatch <= differ;
        end
    end
endmodule : dosm_sid_check

// File: hdl/dosm_dev.sv
/*
 Device end of a bulk OUT stream pipe: Start Stream End and move-data logic.
 Assumes the host end keeps its own obligations and DPs come as single pulses.
*/
`timescale 1ns/100ps
// Behaviour
// - NoStream zero-length DP rejects proposal
// - Start Stream End answers NRDY NoStream, Idle
// - Move Data entry loads current stream
// - first DP PP clear: host terminate
// - first DP PP set: device acknowledge
// - exits go Idle with retry clear
// - retries keep pipe in Move Data
// - foreign stream ID recommends endpoint halt
// - inactive stream may be rejected or stalled
// - buffer left: ACK NumP nonzero, host data
// - host continues burst through retries
// - buffer exhausted: ACK NumP zero, Idle
// - NRDY current stream ends transfer, drops data
// - host data PP set: back to acknowledge
// - host data PP clear: host terminate
// - host PP set unless final DP
// - deferred header in host data: Idle
// - terminate with no buffer: ACK zero, Idle
// - terminate with buffer: ACK, Idle, Not Ready
// - terminate with error: ACK retry, host data
// - terminate may NRDY current stream, Idle
module dosm_dev (
    input wire logic clk,
    input wire logic rst,
    dosm_link_if.dev link,
    input wire logic propose,
    input wire logic [15:0] propose_sid,
    input wire logic stream_active,
    input wire logic stall_inactive,
    input wire logic flow_ctrl,
    input wire logic [4:0] buf_space,
    output logic [15:0] cur_sid,
    output logic [5:0] pipe_state,
    output logic not_ready_pulse,
    output logic proposal_rejected,
    output logic payload_accept,
    output logic payload_drop,
    output logic halt_ep,
    output logic stall_ep
);
    dosm_pkg::dosm_state_e state_r, state_nxt;
    logic [15:0] cur_sid_r;
    logic [15:0] prop_sid_r;
    logic first_r;
    // Error flag is held from the DP; the link lines may move once the pulse ends
    logic err_r;
    logic mismatch;

    wire in_md = (state_r == dosm_pkg::DOSM_DEV) || (state_r == dosm_pkg::DOSM_HOST)
        || (state_r == dosm_pkg::DOSM_HTERM);
    wire dp = link.dp_valid && !link.dp_deferred;
    wire dph_def = link.dp_valid && link.dp_deferred;
    wire has_buf = buf_space != dosm_pkg::NUMP_ZERO;
    wire ss_reject = dp && (link.dp_sid == dosm_pkg::SID_NOSTREAM) && link.dp_zero_len
        && !link.dp_pp && !link.dp_err;
    wire ss_accept = dp && (link.dp_sid != dosm_pkg::SID_NOSTREAM)
        && (link.dp_sid != dosm_pkg::SID_PRIME);
    wire idle_himd = dp && (link.dp_sid != dosm_pkg::SID_PRIME)
        && (link.dp_sid != dosm_pkg::SID_NOSTREAM);
    wire enter_md = ((state_r == dosm_pkg::DOSM_SS) && ss_accept)
        || ((state_r == dosm_pkg::DOSM_IDLE) && idle_himd);
    // Only the first answer after entry may refuse an inactive stream
    wire reject_first = first_r && !stream_active;
    wire ack_step = (state_r == dosm_pkg::DOSM_DEV) && !flow_ctrl && !reject_first;
    wire term_step = (state_r == dosm_pkg::DOSM_HTERM) && !flow_ctrl;
    wire nrdy_step = ((state_r == dosm_pkg::DOSM_DEV) && (flow_ctrl || reject_first))
        || ((state_r == dosm_pkg::DOSM_HTERM) && flow_ctrl);

    // Registered compare: the halt lands two cycles after the foreign packet
    dosm_sid_check u_sid (
        .clk(clk),
        .rst(rst),
        .check_en(in_md && link.dp_valid),
        .pkt_sid(link.dp_sid),
        .cur_sid(cur_sid_r),
        .mismatch(mismatch)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dosm_pkg::DOSM_IDLE: begin
                if (propose) state_nxt = dosm_pkg::DOSM_SS;
                else if (enter_md) state_nxt = link.dp_pp ? dosm_pkg::DOSM_DEV
                    : dosm_pkg::DOSM_HTERM;
            end
            dosm_pkg::DOSM_SS: begin
                if (ss_reject) state_nxt = dosm_pkg::DOSM_SS_END;
                else if (enter_md) state_nxt = link.dp_pp ? dosm_pkg::DOSM_DEV
                    : dosm_pkg::DOSM_HTERM;
                // Deferred header drops the proposal; the device proposes again later
                else if (dph_def) state_nxt = dosm_pkg::DOSM_IDLE;
            end
            dosm_pkg::DOSM_SS_END: state_nxt = dosm_pkg::DOSM_IDLE;
            dosm_pkg::DOSM_DEV: begin
                if (nrdy_step) state_nxt = dosm_pkg::DOSM_IDLE;
                else if (has_buf) state_nxt = dosm_pkg::DOSM_HOST;
                else state_nxt = dosm_pkg::DOSM_IDLE;
            end
            dosm_pkg::DOSM_HOST: begin
                if (dph_def) state_nxt = dosm_pkg::DOSM_IDLE;
                else if (dp && link.dp_pp) state_nxt = dosm_pkg::DOSM_DEV;
                else if (dp) state_nxt = dosm_pkg::DOSM_HTERM;
            end
            dosm_pkg::DOSM_HTERM: begin
                if (nrdy_step) state_nxt = dosm_pkg::DOSM_IDLE;
                else if (err_r) state_nxt = dosm_pkg::DOSM_HOST;
                else state_nxt = dosm_pkg::DOSM_IDLE;
            end
            default: state_nxt = dosm_pkg::DOSM_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= dosm_pkg::DOSM_IDLE;
            cur_sid_r <= dosm_pkg::SID_RESET;
            prop_sid_r <= dosm_pkg::SID_RESET;
            first_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (dp) err_r <= link.dp_err;
            if (propose && state_r == dosm_pkg::DOSM_IDLE) prop_sid_r <= propose_sid;
            if (enter_md) cur_sid_r <= link.dp_sid;
            if (enter_md) first_r <= 1'b1;
            else if (state_r != dosm_pkg::DOSM_IDLE && state_r != dosm_pkg::DOSM_SS) begin
                first_r <= 1'b0;
            end
        end
    end

    // Response path: one answer per DP, all registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            link.rsp_valid <= 1'b0;
            link.rsp_kind <= dosm_pkg::DOSM_RSP_ACK;
            link.rsp_sid <= dosm_pkg::SID_RESET;
            link.rsp_nump <= dosm_pkg::NUMP_ZERO;
            link.rsp_rty <= 1'b0;
            not_ready_pulse <= 1'b0;
            proposal_rejected <= 1'b0;
            payload_accept <= 1'b0;
            payload_drop <= 1'b0;
            stall_ep <= 1'b0;
        end else begin
            link.rsp_valid <= 1'b0;
            link.rsp_rty <= 1'b0;
            not_ready_pulse <= 1'b0;
            proposal_rejected <= 1'b0;
            payload_accept <= 1'b0;
            payload_drop <= 1'b0;
            if (state_r == dosm_pkg::DOSM_SS_END) begin
                link.rsp_valid <= 1'b1;
                link.rsp_kind <= dosm_pkg::DOSM_RSP_NRDY;
                link.rsp_sid <= dosm_pkg::SID_NOSTREAM;
                link.rsp_nump <= dosm_pkg::NUMP_ZERO;
                proposal_rejected <= 1'b1;
            end else if (nrdy_step) begin
                link.rsp_valid <= 1'b1;
                link.rsp_kind <= dosm_pkg::DOSM_RSP_NRDY;
                link.rsp_sid <= cur_sid_r;
                link.rsp_nump <= dosm_pkg::NUMP_ZERO;
                payload_drop <= 1'b1;
                if (reject_first && stall_inactive) stall_ep <= 1'b1;
            end else if (ack_step || term_step) begin
                link.rsp_valid <= 1'b1;
                link.rsp_kind <= dosm_pkg::DOSM_RSP_ACK;
                link.rsp_sid <= cur_sid_r;
                if (term_step && err_r) begin
                    link.rsp_nump <= has_buf ? buf_space : dosm_pkg::NUMP_RESET;
                    link.rsp_rty <= 1'b1;
                end else begin
                    link.rsp_nump <= buf_space;
                    payload_accept <= 1'b1;
                    not_ready_pulse <= term_step && has_buf;
                end
            end
        end
    end

    // Halt is sticky: only a reset clears it, so a stray ID is never lost
    always_ff @(posedge clk) begin
        if (rst) begin
            halt_ep <= 1'b0;
        end else if (mismatch) begin
            halt_ep <= 1'b1;
        end
    end

    // Status outputs trail the state by one cycle to stay flop-driven
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_sid <= dosm_pkg::SID_RESET;
            pipe_state <= dosm_pkg::DOSM_IDLE;
        end else begin
            cur_sid <= cur_sid_r;
            pipe_state <= state_r;
        end
    end
endmodule : dosm_dev

// File: hdl/dosm_host.sv
/*
 Host end of a bulk OUT stream pipe: sends DPs, follows ACK and NRDY.
 Assumes the device answers each DP once, two cycles after it.
*/
`timescale 1ns/100ps
module dosm_host (
    input wire logic clk,
    input wire logic rst,
    dosm_link_if.host link,
    input wire logic start,
    input wire logic [15:0] start_sid,
    input wire logic [7:0] pkt_count,
    input wire logic inject_err,
    input wire logic send_deferred,
    output logic busy,
    output logic done,
    output logic [7:0] sent_count
);
    logic [7:0] left_r;
    logic [15:0] sid_r;
    logic wait_r;
    logic [7:0] sent_r;
    wire last = left_r == 8'h01;
    wire rsp_ack = link.rsp_valid && link.rsp_kind == dosm_pkg::DOSM_RSP_ACK;
    wire exit_rsp = link.rsp_valid && !link.rsp_rty
        && (link.rsp_kind == dosm_pkg::DOSM_RSP_NRDY
        || link.rsp_nump == dosm_pkg::NUMP_ZERO || last);
    wire retry = rsp_ack && link.rsp_rty;
    wire advance = rsp_ack && !link.rsp_rty && !exit_rsp;

    always_ff @(posedge clk) begin
        if (rst) begin
            link.dp_valid <= 1'b0;
            link.dp_sid <= dosm_pkg::SID_RESET;
            link.dp_pp <= 1'b0;
            link.dp_err <= 1'b0;
            link.dp_deferred <= 1'b0;
            link.dp_zero_len <= 1'b0;
            left_r <= 8'h00;
            sid_r <= dosm_pkg::SID_RESET;
            wait_r <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            sent_r <= 8'h00;
        end else begin
            link.dp_valid <= 1'b0;
            done <= 1'b0;
            if (!busy && start && pkt_count != 8'h00) begin
                busy <= 1'b1;
                sid_r <= start_sid;
                left_r <= pkt_count;
                link.dp_valid <= 1'b1;
                link.dp_sid <= start_sid;
                link.dp_pp <= pkt_count != 8'h01;
                link.dp_err <= inject_err;
                link.dp_deferred <= 1'b0;
                link.dp_zero_len <= 1'b0;
                wait_r <= 1'b1;
            end else if (busy && wait_r && exit_rsp) begin
                busy <= 1'b0;
                wait_r <= 1'b0;
                done <= 1'b1;
                sent_r <= sent_r + 8'h01;
            end else if (busy && wait_r && (retry || advance)) begin
                link.dp_valid <= 1'b1;
                link.dp_sid <= sid_r;
                if (advance) begin
                    left_r <= left_r - 8'h01;
                    sent_r <= sent_r + 8'h01;
                end
                link.dp_pp <= advance ? (left_r > 8'h02) : !last;
                link.dp_err <= 1'b0;
                link.dp_deferred <= send_deferred;
                if (send_deferred) begin
                    busy <= 1'b0;
                    wait_r <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    assign sent_count = sent_r;
endmodule : dosm_host

// File: dv/dosm_link_properties.sv
/* Link checker for the OUT stream pipe.
 Assumes one clock, sync active-high reset, instantiated beside the link. */
`timescale 1ns/100ps
module dosm_link_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic dp_valid,
    input wire logic [15:0] dp_sid,
    input wire logic dp_pp,
    input wire logic dp_err,
    input wire logic dp_deferred,
    input wire logic dp_zero_len,
    input wire logic rsp_valid,
    input wire dosm_pkg::dosm_rsp_e rsp_kind,
    input wire logic [15:0] rsp_sid,
    input wire logic [4:0] rsp_nump,
    input wire logic rsp_rty
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire ack = rsp_valid && rsp_kind == dosm_pkg::DOSM_RSP_ACK;
    wire nrdy = rsp_valid && rsp_kind == dosm_pkg::DOSM_RSP_NRDY;
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    rsp_cause_a: assert property (rsp_valid |-> $past(dp_valid, 2))
        else $error("response without a packet");
    dp_answer_a: assert property (dp_valid && !dp_deferred |-> ##2 rsp_valid)
        else $error("packet left unanswered");
    rsp_sid_a: assert property (rsp_valid |-> rsp_sid == $past(dp_sid, 2))
        else $error("response stream id differs");
    exit_rty_a: assert property (nrdy || (ack && rsp_nump == 5'h00) |-> !rsp_rty)
        else $error("exit response carries retry");
    retry_nump_a: assert property (ack && rsp_rty |-> rsp_nump != 5'h00 && $past(dp_err, 2))
        else $error("bad retry acknowledge");
    deferred_quiet_a: assert property (dp_valid && dp_deferred |-> ##1 !rsp_valid [*3])
        else $error("deferred header answered");
    retry_resend_a: assert property (ack && rsp_rty |-> ##[1:8] dp_valid)
        else $error("host did not retry");
    cover property (ack && rsp_rty);
    cover property (nrdy);
    cover property (ack && rsp_nump == 5'h00);
endmodule : dosm_link_properties

// File: dv/tb.sv
/* Bench: device and host ends on one link, plus a second device driven directly.
 Assumes the hdl/ files are compiled first. */
`timescale 1ns/100ps
module tb;
    logic clk = 0, rst = 1, start = 0, inject_err = 0, send_deferred = 0, propose2 = 0;
    logic stream_active = 1, stall_inactive = 0, flow_ctrl = 0;
    logic [15:0] start_sid = 16'h0001, cur_sid, cur_sid2;
    logic [7:0] pkt_count = 8'h01;
    logic [4:0] buf_space = 5'h03;
    logic [5:0] pipe_state, pipe_state2;
    logic not_ready_pulse, payload_accept, halt_ep, stall_ep, halt2, done;
    logic payload_drop, rejected2, host_busy;
    logic [7:0] sent_count;
    int fails = 0, n_tests = 0, n_ack, n_nrdy, n_nr, n_acc, n_rty, n_drop;
    dosm_link_if lk (.clk(clk));
    dosm_link_if lk2 (.clk(clk));
    dosm_dev dosm_dev_inst (.clk(clk), .rst(rst), .link(lk.dev), .propose(1'b0),
        .propose_sid(16'h0000), .stream_active(stream_active), .stall_inactive(stall_inactive),
        .flow_ctrl(flow_ctrl), .buf_space(buf_space), .cur_sid(cur_sid), .pipe_state(pipe_state),
        .not_ready_pulse(not_ready_pulse), .proposal_rejected(), .payload_accept(payload_accept),
        .payload_drop(payload_drop), .halt_ep(halt_ep), .stall_ep(stall_ep));
    // Second device reaches packets the host end never makes
    dosm_dev dosm_dev_inst2 (.clk(clk), .rst(rst), .link(lk2.dev), .propose(propose2),
        .propose_sid(16'h0009), .stream_active(stream_active), .stall_inactive(stall_inactive),
        .flow_ctrl(flow_ctrl), .buf_space(buf_space), .cur_sid(cur_sid2),
        .pipe_state(pipe_state2), .not_ready_pulse(), .proposal_rejected(rejected2),
        .payload_accept(),
        .payload_drop(), .halt_ep(halt2), .stall_ep());
    dosm_host dosm_host_inst (.clk(clk), .rst(rst), .link(lk.host), .start(start),
        .start_sid(start_sid), .pkt_count(pkt_count), .inject_err(inject_err),
        .send_deferred(send_deferred), .busy(host_busy), .done(done),
        .sent_count(sent_count));
    dosm_link_properties dosm_link_properties_inst (.clk(clk), .rst(rst),
        .dp_valid(lk.dp_valid), .dp_sid(lk.dp_sid), .dp_pp(lk.dp_pp), .dp_err(lk.dp_err),
        .dp_deferred(lk.dp_deferred), .dp_zero_len(lk.dp_zero_len), .rsp_valid(lk.rsp_valid),
        .rsp_kind(lk.rsp_kind), .rsp_sid(lk.rsp_sid), .rsp_nump(lk.rsp_nump),
        .rsp_rty(lk.rsp_rty));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        if (lk.rsp_valid === 1'b1 && lk.rsp_kind === dosm_pkg::DOSM_RSP_ACK) n_ack++;
        if (lk.rsp_valid === 1'b1 && lk.rsp_kind === dosm_pkg::DOSM_RSP_NRDY) n_nrdy++;
        if (lk.rsp_valid === 1'b1 && lk.rsp_rty === 1'b1) n_rty++;
        if (not_ready_pulse === 1'b1) n_nr++;
        if (payload_accept === 1'b1) n_acc++;
        if (payload_drop === 1'b1) n_drop++;
    end
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    // One host transfer; mid_df turns the packet sent on the second ACK into a deferred header
    task automatic run(input logic [15:0] sid, input logic [7:0] cnt, input bit mid_df);
        int k;
        n_ack = 0; n_nrdy = 0; n_nr = 0; n_acc = 0; n_rty = 0; k = 0; n_drop = 0;
        start_sid = sid; pkt_count = cnt; start = 1;
        @(negedge clk) start = 0;
        while (k < 400 && done !== 1'b1) begin
            @(negedge clk);
            if (mid_df && n_ack > 0) send_deferred = 1;
            k++;
        end
        send_deferred = 0;
        chk(k < 400, "host never done");
        repeat (4) @(negedge clk);
        chk(pipe_state === dosm_pkg::DOSM_IDLE, "pipe not idle");
        chk(host_busy === 1'b0, "host still busy");
    endtask : run
    // Directly driven packet; released sid, pp and err lines show the inverse, answer seen on return
    task automatic dp2(input logic [15:0] sid, input logic pp, input logic err, input logic zl);
        lk2.dp_sid = sid; lk2.dp_pp = pp; lk2.dp_err = err; lk2.dp_zero_len = zl;
        lk2.dp_valid = 1;
        @(negedge clk) lk2.dp_valid = 0;
        lk2.dp_sid = ~sid; lk2.dp_pp = ~pp; lk2.dp_err = ~err;
        @(negedge clk);
    endtask : dp2
    initial begin
        lk2.dp_valid = 0; lk2.dp_sid = 16'h0000; lk2.dp_pp = 0; lk2.dp_err = 0;
        lk2.dp_deferred = 0; lk2.dp_zero_len = 0;
        #(25 * 20000);
        fails++;
        wrap_up();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 0;
        @(negedge clk);
        run(16'h0005, 8'h03, 0);
        chk(n_ack == 3 && n_nrdy == 0 && n_acc == 3, "burst acks");
        chk(n_nr == 1, "stream not marked not ready");
        chk(cur_sid === 16'h0005, "current stream");
        run(16'h0007, 8'h01, 0);
        chk(n_ack + n_nrdy == 1 && cur_sid === 16'h0007, "single packet");
        inject_err = 1;
        run(16'h000A, 8'h01, 0);
        inject_err = 0;
        chk(n_rty == 1 && n_ack == 2 && n_acc == 1, "retry burst");
        run(16'h000C, 8'h03, 1);
        chk(n_ack == 2 && halt_ep === 1'b0, "deferred header");
        propose2 = 1;
        @(negedge clk) propose2 = 0;
        @(negedge clk);
        dp2(dosm_pkg::SID_NOSTREAM, 0, 0, 1);
        chk(lk2.rsp_valid === 1'b1 && lk2.rsp_kind === dosm_pkg::DOSM_RSP_NRDY, "reject");
        chk(lk2.rsp_sid === dosm_pkg::SID_NOSTREAM, "reject id");
        chk(rejected2 === 1'b1, "proposal not rejected");
        dp2(16'h0004, 1, 0, 0);
        chk(lk2.rsp_kind === dosm_pkg::DOSM_RSP_ACK && lk2.rsp_nump === 5'h03, "ack");
        dp2(16'h0004, 0, 1, 0);
        chk(lk2.rsp_rty === 1'b1 && lk2.rsp_nump !== 5'h00, "final retry");
        repeat (2) @(negedge clk);
        chk(pipe_state2 === dosm_pkg::DOSM_HOST, "back to host data");
        dp2(16'h0006, 1, 0, 0);
        chk(halt2 === 1'b1 && cur_sid2 === 16'h0004, "foreign stream");
        buf_space = 5'h00;
        run(16'h0008, 8'h03, 0);
        chk(n_ack == 1 && n_acc == 1, "buffer exhausted");
        buf_space = 5'h03; flow_ctrl = 1;
        run(16'h0009, 8'h03, 0);
        chk(n_nrdy == 1 && n_ack == 0 && n_acc == 0 && n_drop == 1, "flow control");
        flow_ctrl = 0; stream_active = 0; stall_inactive = 1;
        run(16'h000B, 8'h03, 0);
        chk(n_nrdy == 1 && stall_ep === 1'b1, "inactive stream");
        chk(sent_count === 8'h0A, "host sent count");
        wrap_up();
    end
endmodule : tb
